// ===== shared/ssb_consts.svh
// Bit positions, reset values and sizes of the status summary block
`ifndef SSB_CONSTS_SVH
`define SSB_CONSTS_SVH
`define SSB_BYTE_W           8
`define SSB_CODE_W           16
`define SSB_STB_QUEUE_BIT    2
`define SSB_STB_QUES_BIT     3
`define SSB_STB_MSG_BIT      4
`define SSB_STB_EVENT_BIT    5
`define SSB_STB_SUMMARY_BIT  6
`define SSB_STB_OPER_BIT     7
`define SSB_STB_USED         8'hfc
`define SSB_ESF_OPC_BIT      0
`define SSB_ESF_QUERY_BIT    2
`define SSB_ESF_DEVICE_BIT   3
`define SSB_ESF_EXEC_BIT     4
`define SSB_ESF_CMD_BIT      5
`define SSB_ESF_USER_BIT     6
`define SSB_ESF_POWER_BIT    7
`define SSB_ESF_USED         8'hfd
`define SSB_ESF_RESET        8'h80
`define SSB_MASK_RESET       8'h00
`define SSB_QUEUE_DEPTH      16
`define SSB_QUEUE_AW         4
`define SSB_NO_ERROR         16'h0000
`endif

// ===== shared/ssb_pkg.sv
// Types shared by the status summary block
package ssb_pkg;
  typedef enum logic [3:0] {
    SSB_CMD_NONE         = 4'h0,
    SSB_CMD_READ_STATUS  = 4'h1,
    SSB_CMD_SERIAL_POLL  = 4'h2,
    SSB_CMD_WRITE_SRM    = 4'h3,
    SSB_CMD_READ_SRM     = 4'h4,
    SSB_CMD_READ_EVENTS  = 4'h5,
    SSB_CMD_WRITE_ESM    = 4'h6,
    SSB_CMD_READ_ESM     = 4'h7,
    SSB_CMD_OPC          = 4'h8,
    SSB_CMD_CLEAR_STATUS = 4'h9,
    SSB_CMD_READ_ERROR   = 4'ha
  } ssb_cmd_t;
  typedef enum logic [1:0] {
    SSB_ERR_QUERY   = 2'h0,
    SSB_ERR_DEVICE  = 2'h1,
    SSB_ERR_EXEC    = 2'h2,
    SSB_ERR_COMMAND = 2'h3
  } ssb_err_class_t;
  typedef enum logic [1:0] {
    SSB_OPC_IDLE = 2'b01,
    SSB_OPC_WAIT = 2'b10
  } ssb_opc_state_t;
endpackage

// ===== shared/ssb_link_if.sv
// Carrier between the status summary core and its event and queue modules
`timescale 1ns/100ps
`default_nettype none
`include "ssb_consts.svh"
interface ssb_link_if;
  logic [`SSB_BYTE_W-1:0] evt_set;
  logic                   evt_clear;
  logic [`SSB_BYTE_W-1:0] evt_flags;
  logic                   q_push;
  logic [`SSB_CODE_W-1:0] q_code;
  logic                   q_pop;
  logic                   q_clear;
  logic [`SSB_CODE_W-1:0] q_head;
  logic                   q_nonempty;
  modport ctrl   (output evt_set, evt_clear, q_push, q_code, q_pop, q_clear,
                  input evt_flags, q_head, q_nonempty);
  modport events (input evt_set, evt_clear, output evt_flags);
  modport queue  (input q_push, q_code, q_pop, q_clear, output q_head, q_nonempty);
endinterface // ssb_link_if
`default_nettype wire

// ===== rtl/ssb_event_flags.sv
// Standard event flags, sticky and cleared on read
`timescale 1ns/100ps
`default_nettype none
`include "ssb_consts.svh"
module ssb_event_flags
  import ssb_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   reset_n,
  ssb_link_if.events  link
);
  logic [`SSB_BYTE_W-1:0] flags;

  assign link.evt_flags = flags;

  // Power-on bit comes up set; a new event wins over a read clear
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      flags <= `SSB_ESF_RESET;
    else if (link.evt_clear)
      flags <= link.evt_set & `SSB_ESF_USED;
    else
      flags <= (flags | link.evt_set) & `SSB_ESF_USED;
  end
endmodule // ssb_event_flags
`default_nettype wire

// ===== rtl/ssb_error_queue.sv
// Error code queue, oldest entry first
`timescale 1ns/100ps
`default_nettype none
`include "ssb_consts.svh"
module ssb_error_queue
  import ssb_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  ssb_link_if.queue  link
);
  logic [`SSB_CODE_W-1:0]  mem [`SSB_QUEUE_DEPTH];
  logic [`SSB_QUEUE_AW-1:0] wr_ptr;
  logic [`SSB_QUEUE_AW-1:0] rd_ptr;
  logic [`SSB_QUEUE_AW:0]   count;
  logic                     do_pop;
  logic                     do_push;

  assign do_pop          = link.q_pop && (count != '0);
  assign do_push         = link.q_push &&
                           ((count != (`SSB_QUEUE_AW+1)'(`SSB_QUEUE_DEPTH)) || do_pop);
  assign link.q_nonempty = (count != '0);
  assign link.q_head     = mem[rd_ptr];

  // Storage; a push into a full queue is dropped unless a pop runs in the same cycle, one in a clearing cycle lands first
  always_ff @(posedge clk)
  begin
    if (link.q_clear && link.q_push)
      mem[0] <= link.q_code;
    else if (do_push)
      mem[wr_ptr] <= link.q_code;
  end

  // Pointers and fill level
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (link.q_clear)
    begin
      wr_ptr <= {{(`SSB_QUEUE_AW-1){1'b0}}, link.q_push};
      rd_ptr <= '0;
      count  <= {{`SSB_QUEUE_AW{1'b0}}, link.q_push};
    end
    else
    begin
      if (do_push)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_pop)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + {{`SSB_QUEUE_AW{1'b0}}, do_push} - {{`SSB_QUEUE_AW{1'b0}}, do_pop};
    end
  end
endmodule // ssb_error_queue
`default_nettype wire

// ===== rtl/ssb_status_summary.sv
// Status summary byte, service request and standard event handling
`timescale 1ns/100ps
`default_nettype none
`include "ssb_consts.svh"
module ssb_status_summary
  import ssb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   cmd_valid,
  input  wire ssb_cmd_t               cmd_code,
  input  wire logic [`SSB_BYTE_W-1:0] cmd_data,
  output logic                        resp_valid,
  output logic [`SSB_CODE_W-1:0]      resp_data,
  input  wire logic                   err_valid,
  input  wire ssb_err_class_t         err_class,
  input  wire logic [`SSB_CODE_W-1:0] err_code,
  input  wire logic                   all_commands_done,
  input  wire logic                   user_request,
  input  wire logic                   ques_summary,
  input  wire logic                   oper_summary,
  input  wire logic                   output_message_waiting,
  output logic [`SSB_BYTE_W-1:0]      status_summary_byte,
  output logic                        service_request,
  output logic                        srq_pulse
);
  ssb_link_if link ();

  logic [`SSB_BYTE_W-1:0] service_request_mask;
  logic [`SSB_BYTE_W-1:0] standard_event_mask;
  logic [`SSB_BYTE_W-1:0] status_low;
  logic [`SSB_BYTE_W-1:0] next_status;
  logic [`SSB_BYTE_W-1:0] enabled_low;
  logic [`SSB_BYTE_W-1:0] prev_enabled;
  logic [`SSB_BYTE_W-1:0] err_bit;
  logic [`SSB_BYTE_W-1:0] opc_bit;
  logic [`SSB_BYTE_W-1:0] user_bit;
  logic                   event_summary_bit;
  logic                   service_request_summary;
  logic                   next_srq;
  logic                   opc_done;
  logic                   clear_status;
  logic                   cmd_write_srm;
  logic                   cmd_write_esm;
  logic                   cmd_read_events;
  logic                   cmd_read_error;
  logic                   cmd_opc;
  logic                   next_resp_valid;
  logic [`SSB_CODE_W-1:0] next_resp_data;
  ssb_opc_state_t         opc_state;

  ssb_event_flags u_events
  (
    .clk     (clk),
    .reset_n (reset_n),
    .link    (link.events)
  );

  ssb_error_queue u_queue
  (
    .clk     (clk),
    .reset_n (reset_n),
    .link    (link.queue)
  );

  // One-hot bit for a numbered position
  function automatic logic [`SSB_BYTE_W-1:0] bit_at(input int unsigned pos);
    logic [`SSB_BYTE_W-1:0] v;
    v = '0;
    v[pos[2:0]] = 1'b1;
    return v;
  endfunction

  // Event flag raised by an error class
  function automatic logic [`SSB_BYTE_W-1:0] class_bit(input ssb_err_class_t c);
    logic [`SSB_BYTE_W-1:0] v;
    v = '0;
    case (c)
      SSB_ERR_QUERY:   v = bit_at(`SSB_ESF_QUERY_BIT);
      SSB_ERR_DEVICE:  v = bit_at(`SSB_ESF_DEVICE_BIT);
      SSB_ERR_EXEC:    v = bit_at(`SSB_ESF_EXEC_BIT);
      SSB_ERR_COMMAND: v = bit_at(`SSB_ESF_CMD_BIT);
      default:         v = '0;
    endcase
    return v;
  endfunction

  // Strobe for one command code taken this cycle
  function automatic logic cmd_hit(input logic valid, input ssb_cmd_t code,
                                   input ssb_cmd_t want);
    return valid && (code == want);
  endfunction

  // Decoded command strobes
  assign clear_status    = cmd_hit(cmd_valid, cmd_code, SSB_CMD_CLEAR_STATUS);
  assign cmd_write_srm   = cmd_hit(cmd_valid, cmd_code, SSB_CMD_WRITE_SRM);
  assign cmd_write_esm   = cmd_hit(cmd_valid, cmd_code, SSB_CMD_WRITE_ESM);
  assign cmd_read_events = cmd_hit(cmd_valid, cmd_code, SSB_CMD_READ_EVENTS);
  assign cmd_read_error  = cmd_hit(cmd_valid, cmd_code, SSB_CMD_READ_ERROR);
  assign cmd_opc         = cmd_hit(cmd_valid, cmd_code, SSB_CMD_OPC);

  // Error reports set their event flag; all but query errors queue their code
  always_comb
  begin
    err_bit = '0;
    if (err_valid)
      err_bit = class_bit(err_class);
  end

  assign opc_done = (opc_state == SSB_OPC_WAIT) && all_commands_done;
  assign opc_bit  = opc_done ? bit_at(`SSB_ESF_OPC_BIT) : '0;
  assign user_bit = user_request ? bit_at(`SSB_ESF_USER_BIT) : '0;

  assign link.evt_set   = err_bit | opc_bit | user_bit;
  assign link.evt_clear = clear_status || cmd_read_events;
  assign link.q_push    = err_valid && (err_class != SSB_ERR_QUERY);
  assign link.q_code    = err_code;
  assign link.q_pop     = cmd_read_error;
  assign link.q_clear   = clear_status;

  // Operation complete waits for all earlier commands
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      opc_state <= SSB_OPC_IDLE;
    else
    begin
      case (opc_state)
        SSB_OPC_IDLE:
          if (cmd_opc)
            opc_state <= SSB_OPC_WAIT;
        SSB_OPC_WAIT:
          if (clear_status || all_commands_done)
            opc_state <= SSB_OPC_IDLE;
        default:
          opc_state <= SSB_OPC_IDLE;
      endcase
    end
  end

  // Service-request mask written by its enable command
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      service_request_mask <= `SSB_MASK_RESET;
    else if (cmd_write_srm)
      service_request_mask <= cmd_data;
  end

  // Standard event mask written by its enable command
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      standard_event_mask <= `SSB_MASK_RESET;
    else if (cmd_write_esm)
      standard_event_mask <= cmd_data;
  end

  // Summary of enabled event flags
  assign event_summary_bit = |(link.evt_flags & standard_event_mask);

  // Lower status bits gathered from their sources
  always_comb
  begin
    status_low = '0;
    status_low[`SSB_STB_QUEUE_BIT] = link.q_nonempty;
    status_low[`SSB_STB_QUES_BIT]  = ques_summary;
    status_low[`SSB_STB_MSG_BIT]   = output_message_waiting;
    status_low[`SSB_STB_EVENT_BIT] = event_summary_bit;
    status_low[`SSB_STB_OPER_BIT]  = oper_summary;
    status_low = status_low & `SSB_STB_USED;
  end

  // Mask bit 6 never takes part in the summary
  assign enabled_low = status_low & service_request_mask &
                       ~bit_at(`SSB_STB_SUMMARY_BIT);
  assign service_request_summary = |enabled_low;

  always_comb
  begin
    next_status = status_low;
    next_status[`SSB_STB_SUMMARY_BIT] = service_request_summary;
  end

  // Request on any enabled rising bit, or on every queue push while mask bit 2 is set
  assign next_srq = |(enabled_low & ~prev_enabled) ||
                    (link.q_push &&
                     service_request_mask[`SSB_STB_QUEUE_BIT]);

  // Status byte output
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      status_summary_byte <= '0;
    else
      status_summary_byte <= next_status;
  end

  // Service request level
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      service_request <= 1'b0;
    else
      service_request <= service_request_summary;
  end

  // Service request pulse
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      srq_pulse <= 1'b0;
    else
      srq_pulse <= next_srq;
  end

  // Enabled bits of the last cycle, for rising edge detection
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      prev_enabled <= '0;
    else
      prev_enabled <= enabled_low;
  end

  // Answer chosen for the command taken this cycle
  always_comb
  begin
    next_resp_valid = 1'b0;
    next_resp_data  = resp_data;
    if (cmd_valid)
    begin
      case (cmd_code)
        SSB_CMD_READ_STATUS, SSB_CMD_SERIAL_POLL:
        begin
          next_resp_valid = 1'b1;
          next_resp_data  = {8'h00, next_status};
        end
        SSB_CMD_READ_SRM:
        begin
          next_resp_valid = 1'b1;
          next_resp_data  = {8'h00, service_request_mask};
        end
        SSB_CMD_READ_EVENTS:
        begin
          next_resp_valid = 1'b1;
          next_resp_data  = {8'h00, link.evt_flags};
        end
        SSB_CMD_READ_ESM:
        begin
          next_resp_valid = 1'b1;
          next_resp_data  = {8'h00, standard_event_mask};
        end
        SSB_CMD_READ_ERROR:
        begin
          next_resp_valid = 1'b1;
          next_resp_data  = link.q_nonempty ? link.q_head : `SSB_NO_ERROR;
        end
        default:
        begin
          next_resp_valid = 1'b0;
        end
      endcase
    end
  end

  // Answer strobe, one cycle after the command
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      resp_valid <= 1'b0;
    else
      resp_valid <= next_resp_valid;
  end

  // Answer data, held until the next answer
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      resp_data <= '0;
    else
      resp_data <= next_resp_data;
  end
endmodule // ssb_status_summary
`default_nettype wire

// ===== sim/ssb_status_summary_sva.sv
// Port checks of the status summary block
`timescale 1ns/100ps
`default_nettype none
module ssb_status_summary_sva
  import ssb_pkg::*;
(
  input wire logic           clk,
  input wire logic           reset_n,
  input wire logic           cmd_valid,
  input wire ssb_cmd_t       cmd_code,
  input wire logic [7:0]     cmd_data,
  input wire logic           resp_valid,
  input wire logic [15:0]    resp_data,
  input wire logic           err_valid,
  input wire ssb_err_class_t err_class,
  input wire logic [15:0]    err_code,
  input wire logic           all_commands_done,
  input wire logic           user_request,
  input wire logic           ques_summary,
  input wire logic           oper_summary,
  input wire logic           output_message_waiting,
  input wire logic [7:0]     status_summary_byte,
  input wire logic           service_request,
  input wire logic           srq_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_unused_zero: assert property (status_summary_byte[1:0] == 2'b00)
    else $error("unused status bits set");
  a_srq_level: assert property (service_request == status_summary_byte[6])
    else $error("service request differs from summary bit");
  a_ques_bit: assert property ($past(reset_n, 2) |->
    status_summary_byte[3] == $past(ques_summary)) else $error("bit 3 wrong");
  a_msg_bit: assert property ($past(reset_n, 2) |->
    status_summary_byte[4] == $past(output_message_waiting)) else $error("bit 4 wrong");
  a_oper_bit: assert property ($past(reset_n, 2) |->
    status_summary_byte[7] == $past(oper_summary)) else $error("bit 7 wrong");
  a_read_answer: assert property (cmd_valid && cmd_code inside {SSB_CMD_READ_STATUS,
    SSB_CMD_SERIAL_POLL, SSB_CMD_READ_SRM, SSB_CMD_READ_EVENTS, SSB_CMD_READ_ESM,
    SSB_CMD_READ_ERROR} |=> resp_valid) else $error("read not answered");
  a_status_answer: assert property (cmd_valid && cmd_code inside {SSB_CMD_READ_STATUS,
    SSB_CMD_SERIAL_POLL} |=> resp_data == {8'h00, status_summary_byte})
    else $error("status answer differs from byte");
  a_srq_cause: assert property (srq_pulse |-> ##[0:1] service_request)
    else $error("request pulse without summary bit");
endmodule // ssb_status_summary_sva
`default_nettype wire

// ===== sim/ssb_host_model.sv
// Remote controller model issuing commands and taking answers
`timescale 1ns/100ps
`default_nettype none
module ssb_host_model
  import ssb_pkg::*;
(
  input wire logic        clk,
  output logic            cmd_valid,
  output ssb_cmd_t        cmd_code,
  output logic [7:0]      cmd_data,
  input wire logic        resp_valid,
  input wire logic [15:0] resp_data
);
  logic [15:0] rdata;
  logic        got;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = SSB_CMD_NONE;
    cmd_data = 8'h00;
  end
  // One command per call, answer taken in the cycle after it
  task automatic send(input ssb_cmd_t c, input logic [7:0] d);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = d;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code = SSB_CMD_NONE;
    cmd_data = ~d;
    got = resp_valid;
    rdata = resp_data;
  endtask
endmodule // ssb_host_model
`default_nettype wire

// ===== sim/status_byte_event_summary_tb.sv
// Self-checking bench of the status summary block
`timescale 1ns/100ps
`default_nettype none
module status_byte_event_summary_tb;
  import ssb_pkg::*;
  logic           clk, reset_n, err_valid, all_commands_done, user_request;
  logic           ques_summary, oper_summary, output_message_waiting;
  logic           cmd_valid, resp_valid, service_request, srq_pulse;
  ssb_cmd_t       cmd_code;
  ssb_err_class_t c;
  ssb_err_class_t err_class;
  logic [7:0]     cmd_data, status_summary_byte;
  logic [15:0]    resp_data, err_code;
  int             error_cnt, n_tests, flags, srm, esm, i;
  int             q[$];
  ssb_status_summary u_ssb_status_summary (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .resp_valid(resp_valid), .resp_data(resp_data), .err_valid(err_valid),
    .err_class(err_class), .err_code(err_code), .all_commands_done(all_commands_done),
    .user_request(user_request), .ques_summary(ques_summary), .oper_summary(oper_summary),
    .output_message_waiting(output_message_waiting),
    .status_summary_byte(status_summary_byte), .service_request(service_request),
    .srq_pulse(srq_pulse));
  ssb_host_model u_ssb_host_model (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .resp_valid(resp_valid), .resp_data(resp_data));
  function automatic logic [7:0] model_byte();
    logic [7:0] b;
    b = {oper_summary, 1'b0, |(flags[7:0] & esm[7:0]), output_message_waiting,
         ques_summary, q.size() != 0, 2'b00};
    b[6] = |(b & srm[7:0] & 8'hbf);
    return b;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input ssb_cmd_t cc, input logic [15:0] exp);
    u_ssb_host_model.send(cc, 8'h00);
    chk(16'(u_ssb_host_model.got), 16'h0001);
    chk(u_ssb_host_model.rdata, exp);
  endtask
  task automatic results();
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #200000;
    error_cnt++;
    results();
  end
  initial
  begin
    reset_n = 1'b0; err_valid = 1'b0; err_class = SSB_ERR_QUERY; err_code = 16'h0000;
    all_commands_done = 1'b1; user_request = 1'b0; ques_summary = 1'b0;
    oper_summary = 1'b0; output_message_waiting = 1'b0;
    error_cnt = 0; n_tests = 0; flags = 8'h80; srm = 0; esm = 0;
    void'($urandom(32'h0766));
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    rd(SSB_CMD_READ_EVENTS, 16'h0080);
    rd(SSB_CMD_READ_EVENTS, 16'h0000);
    flags = 0;
    for (i = 0; i < 8; i++)
    begin
      srm = $urandom % 256;
      esm = $urandom % 256;
      u_ssb_host_model.send(SSB_CMD_WRITE_SRM, srm[7:0]);
      u_ssb_host_model.send(SSB_CMD_WRITE_ESM, esm[7:0]);
      @(posedge clk);
      #1 {ques_summary, oper_summary, output_message_waiting} = 3'($urandom);
      rd(SSB_CMD_READ_SRM, 16'(srm));
      rd(SSB_CMD_READ_ESM, 16'(esm));
      rd(SSB_CMD_READ_STATUS, 16'(model_byte()));
      rd(SSB_CMD_SERIAL_POLL, 16'(model_byte()));
      chk(16'(status_summary_byte), 16'(model_byte()));
      chk(16'(service_request), 16'((model_byte() & 8'h40) != 8'h00));
    end
    srm = 8'h24;
    esm = 8'hff;
    u_ssb_host_model.send(SSB_CMD_WRITE_SRM, 8'h04);
    u_ssb_host_model.send(SSB_CMD_WRITE_ESM, 8'hff);
    srm = 8'h04;
    for (i = 0; i < 24; i++)
    begin
      c = ssb_err_class_t'(i < 4 ? i : $urandom % 4);
      @(posedge clk);
      #1 err_valid = 1'b1;
      err_class = c;
      err_code = 16'(-(100 * (4 - int'(c)) + $urandom % 100));
      if (c != SSB_ERR_QUERY && q.size() < 16)
        q.push_back(err_code);
      flags |= 1 << (int'(c) + 2);
      @(posedge clk);
      #1 err_valid = 1'b0;
      err_code = ~err_code;
      chk(16'(srq_pulse), 16'(srm[2] && c != SSB_ERR_QUERY));
    end
    rd(SSB_CMD_READ_STATUS, 16'(model_byte()));
    rd(SSB_CMD_READ_EVENTS, 16'(flags));
    flags = 0;
    for (i = 0; i < 17; i++)
      rd(SSB_CMD_READ_ERROR, q.size() ? 16'(q.pop_front()) : 16'h0000);
    @(posedge clk);
    #1 user_request = 1'b1;
    all_commands_done = 1'b0;
    @(posedge clk);
    #1 user_request = 1'b0;
    u_ssb_host_model.send(SSB_CMD_OPC, 8'h00);
    repeat (3) @(posedge clk);
    rd(SSB_CMD_READ_EVENTS, 16'h0040);
    all_commands_done = 1'b1;
    repeat (3) @(posedge clk);
    rd(SSB_CMD_READ_EVENTS, 16'h0001);
    @(posedge clk);
    #1 err_valid = 1'b1;
    err_class = SSB_ERR_EXEC;
    err_code = 16'hff38;
    @(posedge clk);
    #1 err_valid = 1'b0;
    u_ssb_host_model.send(SSB_CMD_CLEAR_STATUS, 8'h00);
    rd(SSB_CMD_READ_EVENTS, 16'h0000);
    rd(SSB_CMD_READ_ERROR, 16'h0000);
    rd(SSB_CMD_READ_STATUS, 16'(model_byte()));
    results();
  end
endmodule // status_byte_event_summary_tb
bind ssb_status_summary ssb_status_summary_sva u_ssb_status_summary_sva (.*);
`default_nettype wire
